/* File: hw/gcp_host_port.sv */
// gcp_host_port: memory-mapped host port of the four-lane coprocessor
// assumes a host on sys_clk issuing one-cycle requests; answer after
// two edges, whether read or write
`timescale 1ns/1ps
`include "gcp_params.svh"
module gcp_host_port
  import gcp_pkg::*;
#(
  parameter logic [15:0] COPROC_BASE = 16'h0040,
  parameter logic [7:0] MAX_XFER = 8'hFF,
  parameter logic [7:0] IMPLEMENTATION_CODE_CODE = 8'h3C, // arbitrary value
  parameter logic [3:0] MAJOR_REV = 4'h1, // arbitrary value
  parameter logic [3:0] MINOR_REV = 4'h0 // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic host_req,
  input wire logic host_we,
  input wire logic host_dw,
  input wire logic [31:0] host_addr,
  input wire logic [63:0] host_wdata,
  output logic host_ack,
  output logic [63:0] host_rdata,
  output logic cmp_irq,
  output logic seq_busy
);

  // ************************************************************
  // address decode
  // ************************************************************

  gcp_tgt_e tgt;
  logic base_hit;
  logic wr_lo;
  logic wr_hi;
  logic [63:0] wd;
  logic [1:0] lane;
  logic [1:0] ctl_pair;
  logic [31:0] identification_word;

  // misaligned double-words and foreign bases fall through to none
  assign base_hit = host_req &&
    (host_addr[`GCP_BASE_HI:`GCP_BASE_LO] == COPROC_BASE) &&
    !(host_dw && host_addr[`GCP_ODD_BIT]);

  // region and file selection
  always_comb begin
    tgt = TGT_NONE;
    if (base_hit) begin
      case (host_addr[`GCP_RGN_HI:`GCP_RGN_LO])
        `GCP_RGN_COMP: begin
          if (host_addr[`GCP_G_BIT]) begin
            // lane index plays no part here
            if (!host_addr[`GCP_REG_HI]) tgt = TGT_GLB;
          end else if (host_addr[`GCP_REG_HI:`GCP_LOC_TOP] == 2'h0 &&
                       !host_addr[`GCP_LANE_HI]) begin
            tgt = TGT_LOC;
          end
        end
        `GCP_RGN_CTL: begin
          if (host_addr[`GCP_CTL_HI:`GCP_CTL_TOP] == 9'h000) begin
            tgt = TGT_CTL;
          end
        end
        `GCP_RGN_IRAM: begin
          // refused while running: the port is the sequencer's then
          if (!host_addr[`GCP_IA_TOP] && !host_addr[`GCP_IA_SPARE] &&
              !seq_busy) begin
            tgt = TGT_IRAM;
          end
        end
        default: tgt = TGT_NONE;
      endcase
    end
  end

  // a word write lands in the half named by the odd bit
  assign wr_lo = host_we && (host_dw || !host_addr[`GCP_ODD_BIT]);
  assign wr_hi = host_we && (host_dw || host_addr[`GCP_ODD_BIT]);
  assign wd = host_dw ? host_wdata :
    {host_wdata[31:0], host_wdata[31:0]};
  assign lane = host_addr[`GCP_LANE_LO+1:`GCP_LANE_LO];
  assign ctl_pair = host_addr[`GCP_PAIR_LO+1:`GCP_PAIR_LO];

  // ************************************************************
  // operand files
  // ************************************************************

  logic [63:0] loc_rd [0:3];
  logic [63:0] glb_rd;

  // one private file per lane; only the host port reaches it
  for (genvar l = 0; l < 4; l++) begin : g_lane
    gcp_pram #(
      .AW(5)
    ) u_loc (
      .sys_clk(sys_clk),
      .clk_en(clk_en),
      .addr(host_addr[`GCP_PAIR_LO+4:`GCP_PAIR_LO]),
      .we_lo(wr_lo && tgt == TGT_LOC && lane == 2'(l)),
      .we_hi(wr_hi && tgt == TGT_LOC && lane == 2'(l)),
      .wd(wd),
      .rd(loc_rd[l])
    );
  end

  // shared file: its only write path is the host port
  gcp_pram #(
    .AW(6)
  ) u_glb (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .addr(host_addr[`GCP_PAIR_LO+5:`GCP_PAIR_LO]),
    .we_lo(wr_lo && tgt == TGT_GLB),
    .we_hi(wr_hi && tgt == TGT_GLB),
    .wd(wd),
    .rd(glb_rd)
  );

  // ************************************************************
  // instruction memory and sequencer
  // ************************************************************

  logic [63:0] iram_rd;
  logic [8:0] iram_addr;
  logic [9:0] pc;
  logic fetch;
  logic pc_wr;
  logic halt_drain;
  logic halt_reset;
  logic [31:0] instr_word;

  // the sequencer owns the port whenever it runs
  assign iram_addr = seq_busy ? pc[9:1] :
    host_addr[`GCP_IA_HI:`GCP_PAIR_LO];

  gcp_pram #(
    .AW(9)
  ) u_iram (
    .sys_clk(sys_clk),
    .clk_en(clk_en),
    .addr(iram_addr),
    .we_lo(wr_lo && tgt == TGT_IRAM),
    .we_hi(wr_hi && tgt == TGT_IRAM),
    .wd(wd),
    .rd(iram_rd)
  );

  // pc does not move between fetch and execute
  assign instr_word = pc[0] ? iram_rd[63:32] : iram_rd[31:0];

  // control writes; values above 1023 lose their high bits
  assign pc_wr = wr_lo && tgt == TGT_CTL && ctl_pair == `GCP_CP_PC;
  assign halt_drain = wr_lo && tgt == TGT_CTL &&
    ctl_pair == `GCP_CP_HALT &&
    wd[31:0] == `GCP_HALT_DRAIN;
  assign halt_reset = wr_lo && tgt == TGT_CTL &&
    ctl_pair == `GCP_CP_HALT &&
    wd[31:0] == `GCP_HALT_RESET;

  gcp_seq u_seq (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pc_wr(pc_wr),
    .pc_wdata(wd[9:0]),
    .halt_drain(halt_drain),
    .halt_reset(halt_reset),
    .instr_word(instr_word),
    .pc_q(pc),
    .busy_q(seq_busy),
    .fetch(fetch)
  );

  // ************************************************************
  // compare register
  // ************************************************************

  logic [63:0] cmp_q, cmp_d;

  // host restores both halves; a soft reset clears it
  always_comb begin
    cmp_d = cmp_q;
    if (tgt == TGT_CTL && ctl_pair == `GCP_CP_CMP) begin
      if (wr_lo) cmp_d[31:0] = wd[31:0];
      if (wr_hi) cmp_d[63:32] = wd[63:32];
    end
    if (halt_reset) cmp_d = 64'h0000000000000000;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_q <= 64'h0000000000000000;
      cmp_irq <= 1'b0;
    end else if (clk_en) begin
      cmp_q <= cmp_d;
      cmp_irq <= cmp_d[`GCP_IRQ_BIT];
    end
  end

  // ************************************************************
  // read path
  // ************************************************************

  // read-only; halt reads back as zero
  assign identification_word =
    {8'h00, MAX_XFER, IMPLEMENTATION_CODE_CODE, MAJOR_REV, MINOR_REV};

  gcp_tgt_e rd_tgt_q, rd_tgt_d;
  logic rd_v_q, rd_v_d;
  logic rd_dw_q, rd_dw_d;
  logic rd_odd_q, rd_odd_d;
  logic [1:0] rd_lane_q, rd_lane_d;
  logic [63:0] rd_ctl_q, rd_ctl_d;
  logic [63:0] pair;
  logic [63:0] rdata_d;

  // cycle 0: capture what the answer needs; control read is sampled
  // before any write of the same request lands
  always_comb begin
    rd_v_d = host_req;
    rd_tgt_d = tgt;
    rd_dw_d = host_dw;
    rd_odd_d = host_addr[`GCP_ODD_BIT];
    rd_lane_d = lane;
    case (ctl_pair)
      `GCP_CP_ID: rd_ctl_d = {32'h00000000, identification_word};
      `GCP_CP_CMP: rd_ctl_d = cmp_q;
      `GCP_CP_PC: rd_ctl_d = {31'h00000000, seq_busy,
                              22'h000000, pc};
      default: rd_ctl_d = 64'h0000000000000000;
    endcase
  end

  // cycle 1: pick the file word, fold odd words down
  always_comb begin
    case (rd_tgt_q)
      TGT_LOC: pair = loc_rd[rd_lane_q];
      TGT_GLB: pair = glb_rd;
      TGT_CTL: pair = rd_ctl_q;
      TGT_IRAM: pair = iram_rd;
      default: pair = 64'h0000000000000000;
    endcase
    if (rd_dw_q) begin
      rdata_d = pair;
    end else if (rd_odd_q) begin
      rdata_d = {32'h00000000, pair[63:32]};
    end else begin
      rdata_d = {32'h00000000, pair[31:0]};
    end
  end

  // answer stands one cycle; data holds until the next answer
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_v_q <= 1'b0;
      rd_tgt_q <= TGT_NONE;
      rd_dw_q <= 1'b0;
      rd_odd_q <= 1'b0;
      rd_lane_q <= 2'h0;
      rd_ctl_q <= 64'h0000000000000000;
      host_ack <= 1'b0;
      host_rdata <= 64'h0000000000000000;
    end else if (clk_en) begin
      rd_v_q <= rd_v_d;
      rd_tgt_q <= rd_tgt_d;
      rd_dw_q <= rd_dw_d;
      rd_odd_q <= rd_odd_d;
      rd_lane_q <= rd_lane_d;
      rd_ctl_q <= rd_ctl_d;
      host_ack <= rd_v_q;
      if (rd_v_q) host_rdata <= rdata_d;
    end
  end
endmodule : gcp_host_port

/* File: hw/gcp_params.svh */
// gcp_params.svh: address map, field positions and codes of the host port
// assumes inclusion by the package and by every design file that decodes
// How it works
// - each lane owns a private 64-word file
// - shared 128-word file, lanes only read it
// - base in upper half, G bit, index 9:2
// - lane index picks 0-3; ignored for shared
// - register index 0-127, spare high bit
// - word or aligned double-word, adjacent registers
// - float: sign 31, exponent 30:23, mantissa 22:0
// - integers limited to 25-bit signed range
// - coordinate word: Y high half, X low
// - colour word: red 23:16, green, blue
// - identification fields: count, code, revisions
// - identification at control index 0, read-only
// - 64-bit compare at indices 2 and 3
// - 16 bits per lane; bit 63 interrupts
// - 1,024-word instruction memory, region 100
// - program counter write starts execution
// - status nonzero while running, else zero
// - halt 1 drains, keeps last address
// - halt 2 stops at once, resets
// - control indices 4, 5, 6 decoded
// - stop opcode 12 ends sequencing
`ifndef GCP_PARAMS_SVH
`define GCP_PARAMS_SVH
`define GCP_BASE_HI 31
`define GCP_BASE_LO 16
`define GCP_RGN_HI 15
`define GCP_RGN_LO 14
`define GCP_RGN_COMP 2'h0
`define GCP_RGN_CTL 2'h1
`define GCP_RGN_IRAM 2'h2
`define GCP_G_BIT 13
`define GCP_LANE_HI 12
`define GCP_LANE_LO 10
`define GCP_REG_HI 9
`define GCP_LOC_TOP 8
`define GCP_PAIR_LO 3
`define GCP_ODD_BIT 2
`define GCP_CTL_HI 13
`define GCP_CTL_TOP 5
`define GCP_IA_TOP 13
`define GCP_IA_SPARE 12
`define GCP_IA_HI 11
`define GCP_CP_ID 2'h0
`define GCP_CP_CMP 2'h1
`define GCP_CP_PC 2'h2
`define GCP_CP_HALT 2'h3
`define GCP_HALT_DRAIN 32'h00000001
`define GCP_HALT_RESET 32'h00000002
`define GCP_OP_HI 7
`define GCP_OP_STOP 8'h0C
`define GCP_IRQ_BIT 63
`endif

/* File: hw/gcp_pkg.sv */
// gcp_pkg: types shared by the host port and its sequencer
// assumes gcp_params.svh sits on the include path
package gcp_pkg;
  `include "gcp_params.svh"

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_FETCH = 3'h2,
    SEQ_EXEC = 3'h4
  } gcp_seq_e;

  // target of a host access
  typedef enum logic [2:0] {
    TGT_NONE, TGT_LOC, TGT_GLB, TGT_CTL, TGT_IRAM
  } gcp_tgt_e;

  // operand word layouts
  typedef struct packed {
    logic sign;
    logic [7:0] exponent_field;
    logic [22:0] mantissa_field;
  } gcp_float_s;
  typedef struct packed {
    logic [15:0] y;
    logic [15:0] x;
  } gcp_xy_s;
  typedef struct packed {
    logic [7:0] undef;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } gcp_rgb_s;

  // integer operand fits the 25-bit signed range
  function automatic logic gcp_int_ok(input logic [31:0] v);
    return (&v[31:24]) | ~(|v[31:24]);
  endfunction : gcp_int_ok
endpackage : gcp_pkg

/* File: hw/gcp_pram.sv */
// gcp_pram: register file stored as pairs of words, one port
// assumes the caller resolves host versus sequencer ownership
`timescale 1ns/1ps
module gcp_pram #(
  parameter int AW = 5
) (
  input wire logic sys_clk,
  input wire logic clk_en,
  input wire logic [AW-1:0] addr,
  input wire logic we_lo,
  input wire logic we_hi,
  input wire logic [63:0] wd,
  output logic [63:0] rd
);
  logic [63:0] mem [0:(1<<AW)-1];

  // pair layout lets an aligned double-word land in one cycle
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (we_lo) mem[addr][31:0] <= wd[31:0];
      if (we_hi) mem[addr][63:32] <= wd[63:32];
      rd <= mem[addr];
    end
  end
endmodule : gcp_pram

/* File: hw/gcp_seq.sv */
// gcp_seq: instruction sequencer, fetch then execute per instruction
// assumes instr_word is the memory word at pc_q one cycle after fetch
`timescale 1ns/1ps
`include "gcp_params.svh"
module gcp_seq
  import gcp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic pc_wr,
  input wire logic [9:0] pc_wdata,
  input wire logic halt_drain,
  input wire logic halt_reset,
  input wire logic [31:0] instr_word,
  output logic [9:0] pc_q,
  output logic busy_q,
  output logic fetch
);
  gcp_seq_e state_q, state_d;
  logic [9:0] pc_d;
  logic drain_q, drain_d;

  assign fetch = (state_q == SEQ_FETCH);

  // next state; host writes override the running sequence
  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    drain_d = drain_q | halt_drain;
    case (state_q)
      SEQ_IDLE: drain_d = 1'b0;
      SEQ_FETCH: state_d = SEQ_EXEC;
      SEQ_EXEC: begin
        if (instr_word[`GCP_OP_HI:0] == `GCP_OP_STOP) begin
          state_d = SEQ_IDLE;
        end else if (drain_d) begin
          state_d = SEQ_IDLE;
        end else begin
          pc_d = pc_q + 10'h001;
          state_d = SEQ_FETCH;
        end
      end
      default: state_d = SEQ_IDLE;
    endcase
    if (state_d == SEQ_IDLE) drain_d = 1'b0;
    if (pc_wr) begin
      pc_d = pc_wdata;
      state_d = SEQ_FETCH;
      drain_d = 1'b0;
    end
    if (halt_reset) begin
      pc_d = 10'h000;
      state_d = SEQ_IDLE;
      drain_d = 1'b0;
    end
  end

  // idle after reset until the host loads the program counter
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= SEQ_IDLE;
      pc_q <= 10'h000;
      drain_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      pc_q <= pc_d;
      drain_q <= drain_d;
      busy_q <= (state_d != SEQ_IDLE);
    end
  end
endmodule : gcp_seq

/* File: tb/gcp_host_model.sv */
// gcp_host_model: host cpu issuing one request at a time
// assumes sys_clk from the bench; requests launched on falling edges
`timescale 1ns/1ps
module gcp_host_model (
  input wire logic sys_clk,
  input wire logic host_ack,
  input wire logic [63:0] host_rdata,
  output logic host_req,
  output logic host_we,
  output logic host_dw,
  output logic [31:0] host_addr,
  output logic [63:0] host_wdata
);
  // ****
  // idle bus and transfer task
  // ****
  initial begin
    host_req = 1'b0;
    host_we = 1'b0;
    host_dw = 1'b0;
    host_addr = 32'h0;
    host_wdata = 64'h0;
  end
  // one strobe, then wait bounded for the ack two edges later
  task automatic xfer(input logic we, input logic dw, input logic [31:0] a,
    input logic [63:0] wd, output logic [63:0] rd, output logic ok);
    int n;
    @(negedge sys_clk);
    host_req = 1'b1;
    host_we = we;
    host_dw = dw & ~a[2];
    host_addr = a;
    host_wdata = wd;
    @(negedge sys_clk);
    host_req = 1'b0;
    // released lines show the inverse, not a stale copy
    host_addr = ~a;
    host_wdata = ~wd;
    n = 0;
    while (host_ack !== 1'b1 && n < 6) begin
      @(negedge sys_clk);
      n++;
    end
    rd = host_rdata;
    // ack is registered one edge after the taking edge's capture stage
    ok = (n == 1);
  endtask : xfer
endmodule : gcp_host_model

/* File: tb/gcp_host_port_sva.sv */
// gcp_host_port_sva: port timing and side effects of gcp_host_port
// assumes clk_en drops only with no request in flight; bound to every
// instance
`timescale 1ns/1ps
module gcp_host_port_sva #(
  parameter logic [15:0] COPROC_BASE = 16'h0040,
  parameter logic [7:0] MAX_XFER = 8'hFF,
  parameter logic [7:0] IMPLEMENTATION_CODE_CODE = 8'h3C,
  parameter logic [3:0] MAJOR_REV = 4'h1,
  parameter logic [3:0] MINOR_REV = 4'h0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic host_req,
  input wire logic host_we,
  input wire logic host_dw,
  input wire logic [31:0] host_addr,
  input wire logic [63:0] host_wdata,
  input wire logic host_ack,
  input wire logic [63:0] host_rdata,
  input wire logic cmp_irq,
  input wire logic seq_busy
);
  // ****
  // request kinds and control addresses
  // ****
  localparam logic [31:0] CB = {COPROC_BASE, 16'h4000};
  wire logic req = clk_en && host_req;
  wire logic wr = req && host_we;
  wire logic rd = req && !host_we;
  wire logic pcw = wr && host_addr == CB + 32'h10;
  wire logic hlt = wr && host_addr == CB + 32'h18;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_ACK: assert property (req |-> ##2 host_ack)
    else $error("ack not two cycles after request");
  AST_ACK_CAUSE: assert property (host_ack |-> $past(req, 2))
    else $error("ack without request");
  AST_HOLD: assert property (!host_ack |-> $stable(host_rdata))
    else $error("read data moved between acks");
  AST_WORD: assert property (
    host_ack && $past(rd && !host_dw, 2) |-> host_rdata[63:32] == 32'h0)
    else $error("word read upper half not zero");
  AST_ID: assert property (rd && host_addr == CB |-> ##2
    host_rdata[23:0] == {MAX_XFER, IMPLEMENTATION_CODE_CODE, MAJOR_REV, MINOR_REV})
    else $error("identification fields wrong");
  AST_IRQ: assert property (wr && host_dw && host_addr == CB + 32'h8
    |-> ##2 cmp_irq == $past(host_wdata[63], 2))
    else $error("irq not compare bit 63");
  AST_IRQ_SRC: assert property ($changed(cmp_irq) |->
    $past(wr) || $past(wr, 2))
    else $error("irq moved without host write");
  AST_BUSY_ON: assert property (pcw |-> ##2 seq_busy)
    else $error("pc write did not start");
  AST_BUSY_SRC: assert property ($rose(seq_busy) |-> $past(pcw))
    else $error("sequencer started without pc write");
  AST_HALT2: assert property (hlt && host_wdata[31:0] == 32'h2
    |-> ##2 !seq_busy && !cmp_irq)
    else $error("halt 2 did not reset");
  AST_HALT1: assert property (hlt && host_wdata[31:0] == 32'h1
    |-> ##[1:8] !seq_busy)
    else $error("halt 1 did not drain");
endmodule : gcp_host_port_sva
bind gcp_host_port gcp_host_port_sva #(.COPROC_BASE(COPROC_BASE),
  .MAX_XFER(MAX_XFER), .IMPLEMENTATION_CODE_CODE(IMPLEMENTATION_CODE_CODE), .MAJOR_REV(MAJOR_REV),
  .MINOR_REV(MINOR_REV)) u_gcp_host_port_sva (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .clk_en(clk_en), .host_req(host_req),
  .host_we(host_we), .host_dw(host_dw), .host_addr(host_addr),
  .host_wdata(host_wdata), .host_ack(host_ack), .host_rdata(host_rdata),
  .cmp_irq(cmp_irq), .seq_busy(seq_busy));

/* File: tb/test_geometry_coproc_host_interface.sv */
// test_geometry_coproc_host_interface: self-checking bench of host port
// assumes the host model drives the bus and the checker is bound
`timescale 1ns/1ps
module test_geometry_coproc_host_interface;
  localparam logic [15:0] BASE = 16'h0040;
  localparam logic [23:0] IDF = 24'hFF3C10;
  localparam logic [63:0] NOOP = 64'h0000_0017_0000_0017;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic host_req, host_we, host_dw, host_ack, cmp_irq, seq_busy;
  logic [31:0] host_addr;
  logic [63:0] host_wdata, host_rdata, r;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  always #25 sys_clk = ~sys_clk;
  gcp_host_port #(.COPROC_BASE(BASE), .MAX_XFER(IDF[23:16]),
    .IMPLEMENTATION_CODE_CODE(IDF[15:8]), .MAJOR_REV(IDF[7:4]), .MINOR_REV(IDF[3:0]))
    u_gcp_host_port (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .host_req(host_req), .host_we(host_we), .host_dw(host_dw),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_ack(host_ack),
    .host_rdata(host_rdata), .cmp_irq(cmp_irq), .seq_busy(seq_busy));
  gcp_host_model u_gcp_host_model (.sys_clk(sys_clk), .host_req(host_req),
    .host_we(host_we), .host_dw(host_dw), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_ack(host_ack), .host_rdata(host_rdata));
  // ****
  // address builders and shared checks
  // ****
  function automatic logic [31:0] opa(input logic g, input logic [2:0] ln,
    input logic [7:0] rg);
    return {BASE, 2'h0, g, ln, rg, 2'h0};
  endfunction : opa
  function automatic logic [31:0] ctl(input logic [11:0] ix);
    return {BASE, 2'h1, ix, 2'h0};
  endfunction : ctl
  function automatic logic [31:0] ira(input logic [11:0] ba);
    return {BASE, 4'h8, ba};
  endfunction : ira
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [63:0] ex,
    input logic [63:0] got);
    checked++;
    if (got !== ex) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  task automatic acc(input logic we, input logic dw, input logic [31:0] a,
    input logic [63:0] wd);
    logic ok;
    u_gcp_host_model.xfer(we, dw, a, wd, r, ok);
    chk("ack", 64'h1, {63'h0, ok});
  endtask : acc
  task automatic rdc(input string nm, input logic [31:0] a,
    input logic [63:0] ex);
    acc(1'b0, 1'b0, a, 64'h0);
    chk(nm, ex, r);
  endtask : rdc
  // bounded wait, since a stuck sequencer must not hang the run
  task automatic wait_idle(input int lim);
    int i;
    for (i = 0; i < lim && seq_busy !== 1'b0; i++) begin
      @(negedge sys_clk);
    end
    chk("busy", 64'h0, {63'h0, seq_busy});
  endtask : wait_idle
  // ****
  // scenarios
  // ****
  task automatic t_ident;
    acc(1'b0, 1'b0, ctl(12'h0), 64'h0);
    chk("id", {40'h0, IDF}, {40'h0, r[23:0]});
    acc(1'b1, 1'b0, ctl(12'h0), 64'h0);
    acc(1'b0, 1'b0, ctl(12'h0), 64'h0);
    chk("id ro", {40'h0, IDF}, {40'h0, r[23:0]});
  endtask : t_ident
  task automatic t_oper;
    acc(1'b1, 1'b0, opa(1'b0, 3'h0, 8'h05), 64'h1111_1111);
    acc(1'b1, 1'b0, opa(1'b0, 3'h1, 8'h05), 64'h2222_2222);
    acc(1'b1, 1'b0, opa(1'b1, 3'h0, 8'h7F), 64'h3333_3333);
    acc(1'b1, 1'b1, opa(1'b0, 3'h3, 8'h3E), 64'h5555_5555_4444_4444);
    rdc("lane0", opa(1'b0, 3'h0, 8'h05), 64'h1111_1111);
    rdc("lane1", opa(1'b0, 3'h1, 8'h05), 64'h2222_2222);
    rdc("glob", opa(1'b1, 3'h2, 8'h7F), 64'h3333_3333);
    rdc("dw lo", opa(1'b0, 3'h3, 8'h3E), 64'h4444_4444);
    rdc("dw hi", opa(1'b0, 3'h3, 8'h3F), 64'h5555_5555);
    rdc("unmapped", {BASE, 16'hC000}, 64'h0);
  endtask : t_oper
  task automatic t_cmp;
    acc(1'b1, 1'b1, ctl(12'h2), 64'h8001_0002_0003_0004);
    chk("irq", 64'h1, {63'h0, cmp_irq});
    rdc("cmp lo", ctl(12'h2), 64'h0003_0004);
    rdc("cmp hi", ctl(12'h3), 64'h8001_0002);
    acc(1'b1, 1'b0, ctl(12'h3), 64'h0001_0002);
    chk("irq", 64'h0, {63'h0, cmp_irq});
  endtask : t_cmp
  task automatic t_seq;
    acc(1'b1, 1'b1, ira(12'h000), NOOP);
    acc(1'b1, 1'b1, ira(12'h008), NOOP);
    acc(1'b1, 1'b0, ira(12'h010), 64'h0C);
    rdc("iram", ira(12'h010), 64'h0C);
    acc(1'b1, 1'b0, ctl(12'h4), 64'h0);
    rdc("stat", ctl(12'h5), 64'h1);
    wait_idle(40);
    rdc("stat", ctl(12'h5), 64'h0);
    rdc("pc", ctl(12'h4), 64'h4);
    rdc("halt", ctl(12'h6), 64'h0);
  endtask : t_seq
  task automatic t_halt;
    int i;
    for (i = 0; i < 4096; i += 8) begin
      acc(1'b1, 1'b1, ira(i[11:0]), NOOP);
    end
    acc(1'b1, 1'b1, ctl(12'h2), 64'h8000_0000_0000_0000);
    acc(1'b1, 1'b0, ctl(12'h4), 64'h0);
    acc(1'b1, 1'b0, ctl(12'h6), 64'h2);
    chk("busy", 64'h0, {63'h0, seq_busy});
    chk("irq", 64'h0, {63'h0, cmp_irq});
    rdc("pc", ctl(12'h4), 64'h0);
    acc(1'b1, 1'b0, ctl(12'h4), 64'h0);
    rdc("iram busy", ira(12'h0), 64'h0);
    acc(1'b1, 1'b0, ctl(12'h6), 64'h1);
    wait_idle(8);
    rdc("pc last", ctl(12'h4), 64'h2);
  endtask : t_halt
  // clock enable low must hold a short program mid-run
  task automatic t_freeze;
    acc(1'b1, 1'b0, ira(12'h010), 64'h0C);
    acc(1'b1, 1'b0, ctl(12'h4), 64'h0);
    @(negedge sys_clk);
    clk_en = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk("frozen busy", 64'h1, {63'h0, seq_busy});
    clk_en = 1'b1;
    wait_idle(40);
    rdc("pc thawed", ctl(12'h4), 64'h4);
  endtask : t_freeze
  // main sequence; inputs move on falling edges only
  initial begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk("busy", 64'h0, {63'h0, seq_busy});
    t_ident();
    t_oper();
    t_cmp();
    t_seq();
    t_halt();
    t_freeze();
    final_report();
  end
  // watchdog against a hung handshake
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      final_report();
    end
  end
endmodule : test_geometry_coproc_host_interface
